//--- core/ufs_defines.vh
`ifndef UFS_DEFINES_VH
`define UFS_DEFINES_VH

// Instance count, queue geometry and divisor width
`define UFS_NUM_CH      4
`define UFS_TX_W        8
`define UFS_RX_W        12
`define UFS_DEPTH       32
`define UFS_AW          5
`define UFS_DIV_W       16

// Receive entry field positions (data sits in bits 7:0)
`define UFS_RX_FERR     8
`define UFS_RX_PERR     9
`define UFS_RX_BRK      10
`define UFS_RX_OVR      11

// Receive level at which the ready-to-send pin goes high
`define UFS_RTS_LEVEL   6'd28

// Reset values and shortest data length
`define UFS_LINE_IDLE   1'b1
`define UFS_DIV_RST     16'h0000
`define UFS_LEN_BASE    4'd5

`endif

//--- core/ufs_fifo.v
`timescale 1ns/10ps
`include "ufs_defines.vh"

module ufs_fifo #(
   parameter W  = 8,
   parameter D  = 32,
   parameter AW = 5
) (
   input  wire          clk,
   input  wire          rst,
   input  wire          en,
   input  wire          push,
   input  wire [W-1:0]  wdata,
   input  wire          pop,
   output wire [W-1:0]  rdata,
   output reg           full_q,
   output reg           empty_q,
   output reg  [AW:0]   count_q
);
   reg  [W-1:0]  mem [0:D-1];
   reg  [AW-1:0] wp_q;
   reg  [AW-1:0] rp_q;
   wire          do_push = push & ~full_q;
   wire          do_pop  = pop & ~empty_q;
   reg  [AW:0]   cnt_d;

   assign rdata = mem[rp_q];

   // Next occupancy; push and pop in one cycle cancel
   always @* begin
      cnt_d = count_q;
      if (do_push & ~do_pop)
         cnt_d = count_q + 1'b1;
      else if (do_pop & ~do_push)
         cnt_d = count_q - 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   // Storage and pointers; flags are registered so callers see flops
   always @(posedge clk) begin
      if (rst) begin
         wp_q    <= {AW{1'b0}};
         rp_q    <= {AW{1'b0}};
         count_q <= {(AW+1){1'b0}};
         full_q  <= 1'b0;
         empty_q <= 1'b1;
      end else if (en) begin
         if (do_push) begin
            mem[wp_q] <= wdata;
            wp_q      <= (wp_q == D - 1) ? {AW{1'b0}} : wp_q + 1'b1;
         end
         if (do_pop)
            rp_q <= (rp_q == D - 1) ? {AW{1'b0}} : rp_q + 1'b1;
         count_q <= cnt_d;
         full_q  <= (cnt_d == D);
         empty_q <= (cnt_d == {(AW+1){1'b0}});
      end
   end
endmodule // ufs_fifo

//--- core/ufs_top.v
// Function
// R1: Four independent serial channels, each with own queues, divisor and setup.
// R2: Transmit queue per channel is 8 bits wide and 32 entries deep.
// R3: Receive queue per channel is 12 bits wide and 32 entries deep.
// R4: Top four bits of each receive entry hold that character's error flags.
// R5: Bytes written by the host are serialised onto the transmit line.
// R6: Incoming serial bits are assembled into characters and queued for reading.
// R7: Software divisor sets the bit period for transmit and receive.
// R8: Data length, parity mode and stop-bit count are programmable per channel.
// R9: With flow control, pause on peer not-ready; signal not-ready when nearly full.
// R10: Full duplex normally; half duplex lets only one direction run. Here a send and a receive that start in the same cycle both run.
// R11: Loopback feeds transmitter into receiver internally, outer line stays idle.
// R12: Separately enabled interrupt requests for transmit, receive and error events.
// R13: Channels run on their own without processor involvement.
// R14: Software sets a channel's power enable before using it.
// R15: Power state of the channel group is readable as a status output.
// R16: One shared power domain: any enable powers every channel.
// R17: Frame is low start, data LSB first, optional parity, high stops.
// R18: Receiver flags framing, parity and overrun errors.
`timescale 1ns/10ps
`include "ufs_defines.vh"

module ufs_top #(
   parameter NCH  = `UFS_NUM_CH,
   parameter DEP  = `UFS_DEPTH,
   parameter AW   = `UFS_AW,
   parameter DW   = `UFS_DIV_W
) (
   input  wire                clk,
   input  wire                nrst,
   input  wire                ce,
   input  wire [NCH-1:0]      device_power_enable_control,
   output reg                 device_power_status_indication,
   input  wire [NCH*8-1:0]    tx_data,
   input  wire [NCH-1:0]      tx_wr,
   output wire [NCH-1:0]      tx_full,
   output wire [NCH-1:0]      tx_empty,
   input  wire [NCH-1:0]      rx_pop,
   output reg  [NCH*12-1:0]   rx_data_q,
   output reg  [NCH-1:0]      rx_valid_q,
   input  wire [NCH*DW-1:0]   baud_div,
   input  wire [NCH*2-1:0]    data_len,
   input  wire [NCH-1:0]      parity_en,
   input  wire [NCH-1:0]      parity_odd,
   input  wire [NCH-1:0]      stop_two,
   input  wire [NCH-1:0]      tx_en,
   input  wire [NCH-1:0]      rx_en,
   input  wire [NCH-1:0]      flow_en,
   input  wire [NCH-1:0]      half_duplex,
   input  wire [NCH-1:0]      loopback,
   input  wire [NCH-1:0]      tx_irq_en,
   input  wire [NCH-1:0]      rx_irq_en,
   input  wire [NCH-1:0]      err_irq_en,
   input  wire [NCH-1:0]      err_clr,
   output reg  [NCH-1:0]      err_flag_q,
   output reg  [NCH-1:0]      irq_q,
   input  wire [NCH-1:0]      rxd,
   input  wire [NCH-1:0]      cts_n,
   output reg  [NCH-1:0]      txd_q,
   output reg  [NCH-1:0]      rts_n_q
);
   // Transmit states
   localparam [2:0] T_IDLE  = 3'd0;
   localparam [2:0] T_START = 3'd1;
   localparam [2:0] T_DATA  = 3'd2;
   localparam [2:0] T_PAR   = 3'd3;
   localparam [2:0] T_STOP  = 3'd4;
   // Receive states
   localparam [2:0] R_IDLE  = 3'd0;
   localparam [2:0] R_START = 3'd1;
   localparam [2:0] R_DATA  = 3'd2;
   localparam [2:0] R_PAR   = 3'd3;
   localparam [2:0] R_STOP  = 3'd4;

   ////////////////////////////////////////////////////////////////////////
   // Shared power domain: any single enable powers the whole group
   reg pwr_q;
   always @(posedge clk) begin
      if (!nrst) begin
         pwr_q                          <= 1'b0;
         device_power_status_indication <= 1'b0;
      end else if (ce) begin
         pwr_q                          <= |device_power_enable_control; // R16 R14
         device_power_status_indication <= |device_power_enable_control; // R15
      end
   end

   // Unpowered channels sit in reset; clock enable freezes everything
   wire crst = ~nrst | ~pwr_q;
   wire run  = ce;

   genvar g;
   generate
      for (g = 0; g < NCH; g = g + 1) begin : ch // R1
         // Per-channel setup taps
         wire [DW-1:0] div    = baud_div[DW*g +: DW];
         wire [1:0]    dlen   = data_len[2*g +: 2];
         wire [3:0]    nbits  = {2'b00, dlen} + `UFS_LEN_BASE; // R8
         wire [7:0]    dmask  = 8'hFF >> (2'd3 - dlen);

         // Pin synchronisers; only stage two is read by logic
         reg rxd_s1_q, rxd_s2_q, cts_s1_q, cts_s2_q;

         // Transmit path
         reg  [2:0]    ts_q;
         reg  [DW-1:0] tcnt_q;
         reg  [3:0]    tbit_q;
         reg  [7:0]    tsh_q;
         reg           tpar_q;
         reg           tstop2_q;
         reg           tline_q;
         wire [7:0]    tq_rdata;
         wire          tq_full, tq_empty;

         // Receive path
         reg  [2:0]    rs_q;
         reg  [DW-1:0] rcnt_q;
         reg  [3:0]    rbit_q;
         reg  [7:0]    rsh_q;
         reg           rperr_q;
         reg           ovr_pend_q;
         reg           rprev_q;
         reg           rpush_q;
         reg  [11:0]   rent_q;
         wire [11:0]   rq_rdata;
         wire          rq_full, rq_empty;
         wire [AW:0]   rq_count;

         wire rx_src  = loopback[g] ? tline_q : rxd_s2_q; // R11
         wire tx_busy = (ts_q != T_IDLE);
         wire rx_busy = (rs_q != R_IDLE);
         // Peer not-ready and half-duplex hold-off both gate a new frame
         wire tx_take = (ts_q == T_IDLE) & tx_en[g] & ~tq_empty
                        & ~(flow_en[g] & cts_s2_q)   // R9
                        & ~(half_duplex[g] & rx_busy); // R10
         wire rq_pop  = ~rq_empty & (~rx_valid_q[g] | rx_pop[g]);
         wire [7:0] rdat = (rsh_q >> (4'd8 - nbits));

         // Host writes are dropped while the queue reports full
         ufs_fifo #(.W(`UFS_TX_W), .D(DEP), .AW(AW)) u_txq ( // R2
            .clk     (clk),
            .rst     (crst),
            .en      (run),
            .push    (tx_wr[g]),
            .wdata   (tx_data[8*g +: 8]),
            .pop     (tx_take),
            .rdata   (tq_rdata),
            .full_q  (tq_full),
            .empty_q (tq_empty),
            .count_q ()
         );

         ufs_fifo #(.W(`UFS_RX_W), .D(DEP), .AW(AW)) u_rxq ( // R3
            .clk     (clk),
            .rst     (crst),
            .en      (run),
            .push    (rpush_q),
            .wdata   (rent_q),
            .pop     (rq_pop),
            .rdata   (rq_rdata),
            .full_q  (rq_full),
            .empty_q (rq_empty),
            .count_q (rq_count)
         );

         assign tx_full[g]  = tq_full;
         assign tx_empty[g] = tq_empty;

         // Two-flop synchronisers for the pins
         always @(posedge clk) begin
            if (crst) begin
               rxd_s1_q <= `UFS_LINE_IDLE;
               rxd_s2_q <= `UFS_LINE_IDLE;
               cts_s1_q <= 1'b0;
               cts_s2_q <= 1'b0;
            end else if (run) begin
               rxd_s1_q <= rxd[g];
               rxd_s2_q <= rxd_s1_q;
               cts_s1_q <= cts_n[g];
               cts_s2_q <= cts_s1_q;
            end
         end

         ////////////////////////////////////////////////////////////////////
         // Transmitter: every bit lasts div+1 cycles
         always @(posedge clk) begin
            if (crst) begin
               ts_q     <= T_IDLE;
               tcnt_q   <= `UFS_DIV_RST;
               tbit_q   <= 4'd0;
               tsh_q    <= 8'h00;
               tpar_q   <= 1'b0;
               tstop2_q <= 1'b0;
               tline_q  <= `UFS_LINE_IDLE; // R17
            end else if (run) begin
               case (ts_q)
                  T_IDLE: begin
                     if (tx_take) begin // R5
                        tsh_q  <= tq_rdata & dmask;
                        tpar_q <= (^(tq_rdata & dmask)) ^ parity_odd[g];
                        tcnt_q <= div; // R7
                        tline_q <= 1'b0; // R17
                        ts_q   <= T_START;
                     end
                  end
                  T_START, T_DATA: begin
                     if (tcnt_q != {DW{1'b0}}) begin
                        tcnt_q <= tcnt_q - 1'b1;
                     end else begin
                        tcnt_q <= div;
                        if (ts_q == T_START || tbit_q != nbits) begin
                           tline_q <= tsh_q[0]; // R17
                           tsh_q   <= tsh_q >> 1;
                           tbit_q  <= tbit_q + 1'b1;
                           ts_q    <= T_DATA;
                        end else if (parity_en[g]) begin
                           tline_q <= tpar_q; // R8
                           ts_q    <= T_PAR;
                        end else begin
                           tline_q  <= 1'b1;
                           tstop2_q <= stop_two[g];
                           ts_q     <= T_STOP;
                        end
                     end
                  end
                  T_PAR: begin
                     if (tcnt_q != {DW{1'b0}}) begin
                        tcnt_q <= tcnt_q - 1'b1;
                     end else begin
                        tcnt_q   <= div;
                        tline_q  <= 1'b1;
                        tstop2_q <= stop_two[g];
                        ts_q     <= T_STOP;
                     end
                  end
                  T_STOP: begin
                     if (tcnt_q != {DW{1'b0}}) begin
                        tcnt_q <= tcnt_q - 1'b1;
                     end else if (tstop2_q) begin
                        tcnt_q   <= div; // R8
                        tstop2_q <= 1'b0;
                     end else begin
                        tbit_q <= 4'd0;
                        ts_q   <= T_IDLE;
                     end
                  end
                  default: ts_q <= T_IDLE;
               endcase
            end
         end

         ////////////////////////////////////////////////////////////////////
         // Receiver: samples mid-bit after a falling edge on the line
         always @(posedge clk) begin
            if (crst) begin
               rs_q       <= R_IDLE;
               rcnt_q     <= `UFS_DIV_RST;
               rbit_q     <= 4'd0;
               rsh_q      <= 8'h00;
               rperr_q    <= 1'b0;
               ovr_pend_q <= 1'b0;
               rprev_q    <= `UFS_LINE_IDLE;
               rpush_q    <= 1'b0;
               rent_q     <= 12'h000;
            end else if (run) begin
               rprev_q <= rx_src;
               rpush_q <= 1'b0;
               case (rs_q)
                  R_IDLE: begin
                     // Half duplex ignores the line while sending
                     if (rx_en[g] & rprev_q & ~rx_src
                         & ~(half_duplex[g] & tx_busy)) begin // R10
                        rcnt_q <= div >> 1;
                        rbit_q <= 4'd0;
                        rs_q   <= R_START;
                     end
                  end
                  R_START: begin
                     if (rcnt_q != {DW{1'b0}}) begin
                        rcnt_q <= rcnt_q - 1'b1;
                     end else if (!rx_src) begin
                        rcnt_q <= div; // R7
                        rs_q   <= R_DATA;
                     end else begin
                        rs_q <= R_IDLE; // Glitch, not a start bit
                     end
                  end
                  R_DATA: begin
                     if (rcnt_q != {DW{1'b0}}) begin
                        rcnt_q <= rcnt_q - 1'b1;
                     end else begin
                        rcnt_q <= div;
                        rsh_q  <= {rx_src, rsh_q[7:1]}; // R6 R17
                        rbit_q <= rbit_q + 1'b1;
                        if (rbit_q == nbits - 1'b1)
                           rs_q <= parity_en[g] ? R_PAR : R_STOP;
                     end
                  end
                  R_PAR: begin
                     if (rcnt_q != {DW{1'b0}}) begin
                        rcnt_q <= rcnt_q - 1'b1;
                     end else begin
                        rcnt_q  <= div;
                        rperr_q <= rx_src ^ (^rdat) ^ parity_odd[g]; // R18
                        rs_q    <= R_STOP;
                     end
                  end
                  R_STOP: begin
                     if (rcnt_q != {DW{1'b0}}) begin
                        rcnt_q <= rcnt_q - 1'b1;
                     end else begin
                        // Overrun drops the character and marks the next one
                        if (rq_full) begin
                           ovr_pend_q <= 1'b1; // R18
                        end else begin
                           rpush_q    <= 1'b1;
                           ovr_pend_q <= 1'b0;
                        end
                        rent_q[7:0]            <= rdat;
                        rent_q[`UFS_RX_FERR]   <= ~rx_src; // R4 R18
                        rent_q[`UFS_RX_PERR]   <= rperr_q & parity_en[g]; // R4
                        rent_q[`UFS_RX_BRK]    <= ~rx_src & (rdat == 8'h00); // R4
                        rent_q[`UFS_RX_OVR]    <= ovr_pend_q; // R4
                        rperr_q <= 1'b0;
                        rs_q    <= R_IDLE;
                     end
                  end
                  default: rs_q <= R_IDLE;
               endcase
            end
         end

         ////////////////////////////////////////////////////////////////////
         // Read stage, pins, error flag and interrupt; all outputs are flops
         wire err_ev = (rs_q == R_STOP) & (rcnt_q == {DW{1'b0}})
                       & (~rx_src | (rperr_q & parity_en[g]) | rq_full);
         always @(posedge clk) begin
            if (crst) begin
               rx_data_q[12*g +: 12] <= 12'h000;
               rx_valid_q[g]         <= 1'b0;
               txd_q[g]              <= `UFS_LINE_IDLE;
               rts_n_q[g]            <= 1'b0;
               err_flag_q[g]         <= 1'b0;
               irq_q[g]              <= 1'b0;
            end else if (run) begin
               if (rq_pop) begin
                  rx_data_q[12*g +: 12] <= rq_rdata; // R6
                  rx_valid_q[g]         <= 1'b1;
               end else if (rx_pop[g]) begin
                  rx_valid_q[g] <= 1'b0;
               end
               // Outer line idles high in loopback
               txd_q[g]   <= loopback[g] ? `UFS_LINE_IDLE : tline_q; // R11 R13
               // Threshold below full leaves room for frames already in flight
               rts_n_q[g] <= flow_en[g] & (rq_count >= `UFS_RTS_LEVEL); // R9
               // Set wins over a clear in the same cycle
               err_flag_q[g] <= (err_flag_q[g] & ~err_clr[g]) | err_ev;
               irq_q[g] <= (tx_irq_en[g] & tq_empty)
                           | (rx_irq_en[g] & rx_valid_q[g])
                           | (err_irq_en[g] & err_flag_q[g]); // R12
            end
         end
      end
   endgenerate
endmodule // ufs_top

//--- sim/ufs_properties.sv
`timescale 1ns/10ps
module ufs_chk #(
   parameter NCH = 4,
   parameter DW  = 16
) (
   input logic              clk,
   input logic              nrst,
   input logic              ce,
   input logic [NCH-1:0]    device_power_enable_control,
   input logic              device_power_status_indication,
   input logic [NCH-1:0]    tx_wr,
   input logic [NCH-1:0]    tx_full,
   input logic [NCH-1:0]    tx_empty,
   input logic [NCH-1:0]    rx_pop,
   input logic [NCH*12-1:0] rx_data_q,
   input logic [NCH-1:0]    rx_valid_q,
   input logic [NCH*DW-1:0] baud_div,
   input logic [NCH-1:0]    loopback,
   input logic [NCH-1:0]    tx_irq_en,
   input logic [NCH-1:0]    rx_irq_en,
   input logic [NCH-1:0]    err_irq_en,
   input logic [NCH-1:0]    err_clr,
   input logic [NCH-1:0]    err_flag_q,
   input logic [NCH-1:0]    irq_q,
   input logic [NCH-1:0]    txd_q,
   input logic [NCH-1:0]    rts_n_q
);
   // One clock domain, so clocking and disable are shared
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   wire pw = device_power_status_indication;
   wire on = |device_power_enable_control;

   chk_pwr_shared: assert property (
      $past(ce) && $past(nrst) |-> pw == (|$past(device_power_enable_control)))
      else $error("power status does not follow the enables");
   // Reset itself is the cause here, so this one is never disabled
   chk_reset_idle: assert property (disable iff (1'b0)
      !nrst |=> txd_q == {NCH{1'b1}} && rx_valid_q == '0 && !pw)
      else $error("outputs not idle after reset");
   chk_wr_taken: assert property (
      ce && pw && tx_wr[0] && !tx_full[0] |=> !tx_empty[0])
      else $error("accepted write left queue empty");
   chk_rx_hold: assert property (
      on && pw && rx_valid_q[0] && !rx_pop[0] |=> rx_valid_q[0] && $stable(rx_data_q[11:0]))
      else $error("receive entry changed without pop");
   chk_irq_sum: assert property (
      ce && pw && on |=> irq_q[0] == $past(tx_irq_en[0] & tx_empty[0]
         | rx_irq_en[0] & rx_valid_q[0] | err_irq_en[0] & err_flag_q[0]))
      else $error("interrupt does not match enabled causes");
   chk_err_sticky: assert property (
      on && err_flag_q[0] && !err_clr[0] |=> err_flag_q[0])
      else $error("error flag dropped without clear");
   chk_loop_quiet: assert property (
      loopback[3] [*3] |-> txd_q[3])
      else $error("outer line moved during loopback");
   chk_bit_len: assert property (
      $fell(txd_q[0]) && baud_div[DW-1:0] == 16'h0003 |-> !txd_q[0] [*4])
      else $error("low bit shorter than one bit period");
   chk_rts_backlog: assert property (
      rts_n_q[1] && $past(rts_n_q[1]) |-> rx_valid_q[1])
      else $error("not-ready raised with nothing queued");

   // Main scenarios reached
   cover property (ce && pw && tx_wr[0] && !tx_full[0]);
   cover property ($rose(err_flag_q[0]));
   cover property ($rose(rts_n_q[1]));
endmodule // ufs_chk

bind ufs_top ufs_chk #(.NCH(NCH), .DW(DW)) chk_u (.clk, .nrst, .ce,
   .device_power_enable_control, .device_power_status_indication, .tx_wr, .tx_full,
   .tx_empty, .rx_pop, .rx_data_q, .rx_valid_q, .baud_div, .loopback, .tx_irq_en,
   .rx_irq_en, .err_irq_en, .err_clr, .err_flag_q, .irq_q, .txd_q, .rts_n_q);

//--- sim/ufs_peer.sv
`timescale 1ns/10ps
module ufs_peer #(
   parameter BITP = 4
) (
   input  wire clk,
   input  wire txd,
   input  wire rts_n,
   output reg  line
);
   reg [7:0] got [$];
   reg [7:0] b;
   integer   k;
   initial line = 1'b1;

   // Hold one level for a whole bit period
   task bitout(input v);
      begin
         line = v;
         repeat (BITP) @(posedge clk);
         #10;
      end
   endtask

   // Frame out; stop level is a knob so framing faults can be made
   task send(input [7:0] v, input np, input pb, input sv);
      integer j;
      begin
         while (rts_n !== 1'b0) @(posedge clk);
         @(posedge clk);
         #10;
         bitout(1'b0);
         for (j = 0; j < 8; j = j + 1) bitout(v[j]);
         if (np) bitout(pb);
         bitout(sv);
         line = 1'b1;
      end
   endtask

   // Decode 8-bit frames near bit middle; falling edge sees a settled line
   always begin
      @(negedge clk);
      if (txd === 1'b0) begin
         repeat (BITP / 2) @(negedge clk);
         for (k = 0; k < 8; k = k + 1) begin
            repeat (BITP) @(negedge clk);
            b[k] = txd;
         end
         repeat (BITP) @(negedge clk);
         if (txd === 1'b1) got.push_back(b);
      end
   end
endmodule // ufs_peer

//--- sim/uart_fifo_serial_port_tb_top.sv
`timescale 1ns/10ps
module uart_fifo_serial_port_tb_top;
   reg         clk, nrst, ce;
   reg  [3:0]  device_power_enable_control;
   wire        device_power_status_indication;
   reg  [31:0] tx_data;
   reg  [3:0]  tx_wr, rx_pop, parity_en, parity_odd, stop_two, tx_en, rx_en, flow_en;
   reg  [3:0]  half_duplex, loopback, tx_irq_en, rx_irq_en, err_irq_en, err_clr, cts_r;
   reg  [63:0] baud_div;
   reg  [7:0]  data_len, d;
   wire [3:0]  tx_full, tx_empty, rx_valid_q, err_flag_q, irq_q, txd_q, rts_n_q, rxd, cts_n;
   wire [47:0] rx_data_q;
   wire        peer_line;
   integer     err_total, num_checks, i, n, p, w;
   reg         lb_low, tx_low;
   // Channels 1..3 hear their own line; channel 1 also paces itself
   assign rxd   = {txd_q[3:1], peer_line};
   assign cts_n = {cts_r[3:2], rts_n_q[1], cts_r[0]};
   ufs_top dut_u (.clk, .nrst, .ce, .device_power_enable_control,
      .device_power_status_indication, .tx_data, .tx_wr, .tx_full, .tx_empty, .rx_pop,
      .rx_data_q, .rx_valid_q, .baud_div, .data_len, .parity_en, .parity_odd, .stop_two,
      .tx_en, .rx_en, .flow_en, .half_duplex, .loopback, .tx_irq_en, .rx_irq_en,
      .err_irq_en, .err_clr, .err_flag_q, .irq_q, .rxd, .cts_n, .txd_q, .rts_n_q);
   ufs_peer #(.BITP(4)) peer_u (.clk(clk), .txd(txd_q[0]), .rts_n(rts_n_q[0]),
      .line(peer_line));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Note any low on lines that must stay quiet
   always @(posedge clk) begin
      if (loopback[3] && txd_q[3] === 1'b0) lb_low <= 1'b1;
      if (txd_q[0] === 1'b0) tx_low <= 1'b1;
   end
   ////////////////////////////////////////////////////////////
   task tick;
      begin
         @(posedge clk);
         #10;
      end
   endtask
   task chk(input string nm, input [15:0] got, input [15:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            err_total = err_total + 1;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
         end
      end
   endtask
   // Trailing tick keeps two writes from touching the strobe in one step
   task wr(input integer g, input [7:0] v);
      begin
         tx_data[8*g +: 8] = v;
         tx_wr[g] = 1'b1;
         tick;
         tx_wr[g] = 1'b0;
         tick;
      end
   endtask
   task rd(input integer g, input [11:0] v);
      begin
         w = 0;
         while (rx_valid_q[g] !== 1'b1 && w < 3000) begin
            tick;
            w = w + 1;
         end
         chk("rx valid", rx_valid_q[g], 1'b1);
         chk("rx entry", {4'h0, rx_data_q[12*g +: 12]}, {4'h0, v});
         rx_pop[g] = 1'b1;
         tick;
         rx_pop[g] = 1'b0;
         tick;
      end
   endtask
   task end_of_test;
      begin
         $display("checks %0d errors %0d", num_checks, err_total);
         if (err_total == 0 && num_checks > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   // Cut a hang short well beyond the expected few thousand cycles
   initial begin
      repeat (30000) @(posedge clk);
      err_total = err_total + 1;
      end_of_test;
   end
   ////////////////////////////////////////////////////////////
   initial begin
      {err_total, num_checks, lb_low, tx_low} = 0;
      {nrst, device_power_enable_control, tx_data, tx_wr, rx_pop, parity_en} = 0;
      {parity_odd, stop_two, flow_en, half_duplex, loopback, cts_r} = 0;
      {tx_irq_en, rx_irq_en, err_irq_en, err_clr} = 0;
      {ce, tx_en, rx_en, data_len} = {1'b1, 8'hff, 8'hff};
      baud_div = {4{16'h0003}};
      repeat (20) tick;
      chk("txd idle", txd_q, 4'hf);
      chk("tx empty", tx_empty, 4'hf);
      chk("rx valid", rx_valid_q, 4'h0);
      chk("power", device_power_status_indication, 1'b0);
      nrst = 1'b1;
      tick;
      device_power_enable_control = 4'b0100;
      tick;
      tick;
      chk("power", device_power_status_indication, 1'b1);
      // Peer not ready: byte must wait in the queue
      flow_en[0] = 1'b1;
      cts_r[0] = 1'b1;
      // Let not-ready cross the synchroniser before the byte lands
      repeat (2) tick;
      tx_low = 1'b0;
      wr(0, 8'hA5);
      repeat (60) tick;
      chk("paused line", tx_low, 1'b0);
      chk("paused queue", tx_empty[0], 1'b0);
      cts_r[0] = 1'b0;
      w = 0;
      while (peer_u.got.size() == 0 && w < 2000) begin
         tick;
         w = w + 1;
      end
      d = (peer_u.got.size() != 0) ? peer_u.got.pop_front() : 8'h00;
      chk("peer byte", d, 8'hA5);
      peer_u.send(8'h3C, 1'b0, 1'b0, 1'b1);
      rd(0, 12'h03C);
      // Wrong even parity, then a low stop bit
      parity_en[0] = 1'b1;
      err_irq_en[0] = 1'b1;
      peer_u.send(8'h07, 1'b1, 1'b0, 1'b1);
      rd(0, 12'h207);
      chk("err flag", err_flag_q[0], 1'b1);
      chk("err irq", irq_q[0], 1'b1);
      err_clr[0] = 1'b1;
      tick;
      err_clr[0] = 1'b0;
      tick;
      tick;
      chk("err irq", irq_q[0], 1'b0);
      parity_en[0] = 1'b0;
      peer_u.send(8'h81, 1'b0, 1'b0, 1'b0);
      rd(0, 12'h181);
      err_irq_en[0] = 1'b0;
      tx_irq_en[0] = 1'b1;
      tick;
      tick;
      chk("tx irq", irq_q[0], 1'b1);
      tx_irq_en[0] = 1'b0;
      // Every length, parity mode and stop count through channel 1
      for (n = 0; n < 4; n = n + 1)
         for (p = 0; p < 3; p = p + 1) begin
            data_len[3:2] = n;
            parity_en[1] = (p != 0);
            parity_odd[1] = (p == 2);
            stop_two[1] = p[0];
            d = 8'hC9 - 8'h17 * n - p;
            wr(1, d);
            rd(1, {4'h0, d & (8'hff >> (3 - n))});
         end
      // Fill to refusal, then let the self-paced link drain it
      tx_en[1] = 1'b0;
      tx_wr[1] = 1'b1;
      for (i = 0; i < 33; i = i + 1) begin
         tx_data[15:8] = i;
         tick;
      end
      tx_wr[1] = 1'b0;
      tick;
      chk("tx full", tx_full[1], 1'b1);
      flow_en[1] = 1'b1;
      tx_en[1] = 1'b1;
      w = 0;
      while (rts_n_q[1] !== 1'b1 && w < 3000) begin
         tick;
         w = w + 1;
      end
      chk("rts up", rts_n_q[1], 1'b1);
      repeat (40) tick;
      chk("tx held", tx_empty[1], 1'b0);
      for (i = 0; i < 32; i = i + 1) rd(1, i);
      repeat (100) tick;
      chk("no extra", rx_valid_q[1], 1'b0);
      // Overrun: 34 frames against 33 places; the lost one marks the next
      rx_irq_en[2] = 1'b1;
      for (i = 0; i < 34; i = i + 1) wr(2, i);
      repeat (1600) tick;
      chk("overrun", err_flag_q[2], 1'b1);
      chk("rx irq", irq_q[2], 1'b1);
      rd(2, 12'h000);
      wr(2, 8'h77);
      for (i = 1; i < 33; i = i + 1) rd(2, i);
      rd(2, 12'h877);
      chk("rx irq", irq_q[2], 1'b0);
      loopback[3] = 1'b1;
      wr(3, 8'h5A);
      rd(3, 12'h05A);
      chk("outer line", lb_low, 1'b0);
      end_of_test;
   end
endmodule // uart_fifo_serial_port_tb_top
